/* tec_cfg.svh */
// constants for the triple 16-bit timer/event counter
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// register addresses on the cpu-side port
`define TEC_ADDR_C0_LOW   4'h0
`define TEC_ADDR_C0_HIGH  4'h1
`define TEC_ADDR_C0_CTL   4'h2
`define TEC_ADDR_C1_LOW   4'h3
`define TEC_ADDR_C1_HIGH  4'h4
`define TEC_ADDR_C1_CTL   4'h5
`define TEC_ADDR_C2_LOW   4'h6
`define TEC_ADDR_C2_HIGH  4'h7
`define TEC_ADDR_C2_CTL   4'h8

// mode field encodings (control bits 7:6)
`define TEC_MODE_IDLE     2'h0
`define TEC_MODE_EVENT    2'h1
`define TEC_MODE_TIMER    2'h2
`define TEC_MODE_PULSE    2'h3

// control register layout and reset value
`define TEC_CTL_MODE_HI   7
`define TEC_CTL_MODE_LO   6
`define TEC_CTL_RUN_BIT   4
`define TEC_CTL_EDGE_BIT  3
`define TEC_CTL_RESET     8'h00
`define TEC_CTL_WMASK     8'hd8

// internal clock divider for counter 0 and counter 2
`define TEC_SYS_DIV       4
`define TEC_DIV_LAST      2'h3
`define TEC_COUNT_MAX     16'hffff

`endif

/* tec_pkg.sv */
// types for the triple 16-bit timer/event counter
package tec_pkg;

   typedef struct packed {
      logic [1:0] mode;
      logic       spare5;
      logic       run;
      logic       edge_sel;
      logic [2:0] spare;
   } tec_ctrl_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } tec_req_t;

   typedef enum logic [1:0] {
      TEC_KIND_LOW,
      TEC_KIND_HIGH,
      TEC_KIND_CTL,
      TEC_KIND_NONE
   } tec_kind_t;

   typedef enum logic {
      TEC_PW_WAIT,
      TEC_PW_MEASURE
   } tec_pw_state_t;

endpackage

/* tec_chan.sv */
// one 16-bit count-up channel with preload, event and pulse-width logic
`timescale 1ns/1ps
`include "tec_cfg.svh"

module tec_chan #(
   parameter bit HAS_EXT = 1'b1
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              tick,
   input  wire logic              ext_lvl,
   input  wire tec_pkg::tec_ctrl_t ctrl,
   input  wire logic              pre_wr,
   input  wire logic [15:0]       pre_data,
   output logic [15:0]            count,
   output logic                   ovf,
   output logic                   run_clr
);

   logic [15:0]            preload_reg;
   logic [15:0]            count_reg;
   logic                   ext_prev_reg;
   tec_pkg::tec_pw_state_t pw_reg;
   logic [1:0]             mode;
   logic                   rise;
   logic                   fall;
   logic                   adv;
   logic                   pw_start;
   logic                   pw_stop;
   logic                   pw_on;

   // without an external pin only the timer mode is real
   assign mode = (HAS_EXT || ctrl.mode == `TEC_MODE_TIMER) ? ctrl.mode : `TEC_MODE_IDLE;
   assign rise = ext_lvl & ~ext_prev_reg;
   assign fall = ~ext_lvl & ext_prev_reg;
   // edge low: start on falling, end on return high
   assign pw_start = ctrl.edge_sel ? rise : fall;                      // [RULE21]
   assign pw_stop  = ctrl.edge_sel ? fall : rise;                      // [RULE21]
   assign pw_on = ctrl.run && mode == `TEC_MODE_PULSE;

   always_comb begin
      unique case (mode)
         `TEC_MODE_TIMER: adv = ctrl.run & tick;                       // [RULE18] [RULE19]
         `TEC_MODE_EVENT: adv = ctrl.run & (ctrl.edge_sel ? fall : rise); // [RULE6] [RULE20]
         `TEC_MODE_PULSE: adv = pw_on & (pw_reg == tec_pkg::TEC_PW_MEASURE) & tick; // [RULE18]
         default:         adv = 1'b0;                                  // [RULE22]
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_lvl;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pw_reg <= tec_pkg::TEC_PW_WAIT;
      end else if (!pw_on) begin
         pw_reg <= tec_pkg::TEC_PW_WAIT;
      end else begin
         unique case (pw_reg)
            tec_pkg::TEC_PW_WAIT:    if (pw_start) pw_reg <= tec_pkg::TEC_PW_MEASURE; // [RULE21]
            tec_pkg::TEC_PW_MEASURE: if (pw_stop) pw_reg <= tec_pkg::TEC_PW_WAIT;
         endcase
      end
   end

   // combinational so the run bit drops before the wait state can re-arm
   assign run_clr = pw_on & (pw_reg == tec_pkg::TEC_PW_MEASURE) & pw_stop; // [RULE21]

   // no reset: contents are undefined until software writes them
   always_ff @(posedge clk) begin
      if (pre_wr) begin
         preload_reg <= pre_data;                                      // [RULE8] [RULE10]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= 16'h0000;
      end else if (pre_wr && !ctrl.run) begin
         count_reg <= pre_data;                                        // [RULE9]
      end else if (adv) begin
         if (count_reg == `TEC_COUNT_MAX) begin
            count_reg <= preload_reg;                                  // [RULE7] [RULE10]
         end else begin
            count_reg <= count_reg + 16'h0001;                         // [RULE1]
         end
      end
   end

   assign ovf   = adv && count_reg == `TEC_COUNT_MAX;                  // [RULE7]
   assign count = count_reg;

endmodule

/* tec_top.sv */
// triple 16-bit timer/event counter: register port, clock sources, pins
//
// Overview of operation
// RULE1: three independent 16-bit counters, all counting upward.
// RULE2: counters 0 and 1 time, count events, measure pulses; counter 2 only times.
// RULE3: counter 0 internal clock is system clock divided by four.
// RULE4: counter 1 internal clock is the 32768Hz low-frequency clock.
// RULE5: counter 2 counts only the internal system-derived clock, no external input.
// RULE6: event mode adds exactly one per selected-polarity pin transition.
// RULE7: on passing ffff, raise interrupt request, reload preload, keep counting.
// RULE8: preload register has no reset value; unknown until written.
// RULE9: preload write while counter stopped also loads the live count.
// RULE10: preload write while running reaches the count only at next overflow.
// RULE11: low byte write only fills a holding buffer.
// RULE12: high byte write loads high byte together with buffered low byte.
// RULE13: high byte read latches current low byte into read buffer.
// RULE14: low byte read returns the latched buffer, not the live low byte.
// RULE15: software should write low byte before high byte.
// RULE16: shared pins act as counter inputs only in external-input modes.
// RULE17: software keeps a counter in timer mode when its pin is plain I/O.
// RULE18: control bits 7:6 select mode; 10 timer, 11 pulse width.
// RULE19: control bit 4 is run enable; set runs, clear stops.
// RULE20: control bit 3 low counts rising edges, high counts falling edges.
// RULE21: pulse mode counts from active edge, stops and clears run on return.
// RULE22: mode 01 is event counting; mode 00 leaves the counter idle.
`timescale 1ns/1ps
`include "tec_cfg.svh"

module tec_top (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire tec_pkg::tec_req_t req,
   input  wire logic [1:0]       ext_pin,
   input  wire logic             lf_clk_pin,
   output logic [7:0]            rd_data,
   output logic                  rd_valid,
   output logic [2:0]            irq,
   output logic [1:0]            pin_is_counter_in
);

   logic [1:0]          ext_meta_reg;
   logic [1:0]          ext_sync_reg;
   logic                lf_meta_reg;
   logic                lf_sync_reg;
   logic                lf_prev_reg;
   logic [1:0]          div_reg;
   tec_pkg::tec_ctrl_t  ctrl_reg [3];
   logic [7:0]          wr_buf_reg [3];
   logic [7:0]          rd_buf_reg [3];
   logic [7:0]          rd_data_reg;
   logic                rd_valid_reg;
   logic [2:0]          irq_reg;
   logic [1:0]          pin_sel_reg;
   logic [2:0]          tick;
   logic [2:0]          ext_lvl;
   logic [2:0]          pre_wr;
   logic [2:0]          ovf;
   logic [2:0]          run_clr;
   logic [15:0]         count [3];
   logic [1:0]          sel;
   tec_pkg::tec_kind_t  kind;

   function automatic logic [1:0] chan_of(input logic [3:0] a);
      logic [1:0] c;
      c = 2'h0;
      if (a >= `TEC_ADDR_C1_LOW && a <= `TEC_ADDR_C1_CTL) c = 2'h1;
      if (a >= `TEC_ADDR_C2_LOW && a <= `TEC_ADDR_C2_CTL) c = 2'h2;
      return c;
   endfunction

   function automatic tec_pkg::tec_kind_t kind_of(input logic [3:0] a);
      tec_pkg::tec_kind_t k;
      unique case (a)
         `TEC_ADDR_C0_LOW, `TEC_ADDR_C1_LOW, `TEC_ADDR_C2_LOW:    k = tec_pkg::TEC_KIND_LOW;
         `TEC_ADDR_C0_HIGH, `TEC_ADDR_C1_HIGH, `TEC_ADDR_C2_HIGH: k = tec_pkg::TEC_KIND_HIGH;
         `TEC_ADDR_C0_CTL, `TEC_ADDR_C1_CTL, `TEC_ADDR_C2_CTL:    k = tec_pkg::TEC_KIND_CTL;
         default:                                                 k = tec_pkg::TEC_KIND_NONE;
      endcase
      return k;
   endfunction

   function automatic logic ext_mode(input tec_pkg::tec_ctrl_t c);
      return c.mode == `TEC_MODE_EVENT || c.mode == `TEC_MODE_PULSE;
   endfunction

   // strobe aimed at register kind k of channel c
   function automatic logic chan_hit(input logic               s,
                                     input logic [3:0]         a,
                                     input logic [1:0]         c,
                                     input tec_pkg::tec_kind_t k);
      return s && chan_of(a) == c && kind_of(a) == k;
   endfunction

   assign sel  = chan_of(req.addr);
   assign kind = kind_of(req.addr);

   // pins are asynchronous to clk; only the second stage is read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_meta_reg <= 2'h0;
         ext_sync_reg <= 2'h0;
      end else begin
         ext_meta_reg <= ext_pin;
         ext_sync_reg <= ext_meta_reg;
      end
   end

   // low-frequency clock treated as data; its edge is found after syncing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lf_meta_reg <= 1'b0;
         lf_sync_reg <= 1'b0;
         lf_prev_reg <= 1'b0;
      end else begin
         lf_meta_reg <= lf_clk_pin;
         lf_sync_reg <= lf_meta_reg;
         lf_prev_reg <= lf_sync_reg;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;                                    // [RULE3]
      end
   end

   assign tick[0] = div_reg == `TEC_DIV_LAST;                          // [RULE3]
   assign tick[1] = lf_sync_reg & ~lf_prev_reg;                        // [RULE4]
   assign tick[2] = div_reg == `TEC_DIV_LAST;                          // [RULE5]

   // a pin reaches its counter only in event or pulse mode
   assign ext_lvl[0] = ext_mode(ctrl_reg[0]) & ext_sync_reg[0];        // [RULE16]
   assign ext_lvl[1] = ext_mode(ctrl_reg[1]) & ext_sync_reg[1];        // [RULE16]
   assign ext_lvl[2] = 1'b0;                                           // [RULE5]

   always_comb begin
      pre_wr = 3'h0;
      if (req.wr && kind == tec_pkg::TEC_KIND_HIGH) begin
         pre_wr[sel] = 1'b1;                                           // [RULE12]
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_chan
      tec_chan #(
         .HAS_EXT (i < 2)                                              // [RULE2]
      ) u_chan (
         .clk      (clk),
         .nrst     (nrst),
         .tick     (tick[i]),
         .ext_lvl  (ext_lvl[i]),
         .ctrl     (ctrl_reg[i]),
         .pre_wr   (pre_wr[i]),
         .pre_data ({req.wdata, wr_buf_reg[i]}),                       // [RULE12]
         .count    (count[i]),
         .ovf      (ovf[i]),
         .run_clr  (run_clr[i])
      );

      // software write wins over the hardware clear of the run bit
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            ctrl_reg[i] <= `TEC_CTL_RESET;
         end else if (chan_hit(req.wr, req.addr, 2'(i), tec_pkg::TEC_KIND_CTL)) begin
            ctrl_reg[i] <= req.wdata & `TEC_CTL_WMASK;                 // [RULE18] [RULE19]
         end else if (run_clr[i]) begin
            ctrl_reg[i].run <= 1'b0;                                   // [RULE21]
         end
      end

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            wr_buf_reg[i] <= 8'h00;
         end else if (chan_hit(req.wr, req.addr, 2'(i), tec_pkg::TEC_KIND_LOW)) begin
            wr_buf_reg[i] <= req.wdata;                                // [RULE11]
         end
      end

      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            rd_buf_reg[i] <= 8'h00;
         end else if (chan_hit(req.rd, req.addr, 2'(i), tec_pkg::TEC_KIND_HIGH)) begin
            rd_buf_reg[i] <= count[i][7:0];                            // [RULE13]
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_reg  <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= req.rd;
         if (req.rd) begin
            unique case (kind)
               tec_pkg::TEC_KIND_LOW:  rd_data_reg <= rd_buf_reg[sel]; // [RULE14]
               tec_pkg::TEC_KIND_HIGH: rd_data_reg <= count[sel][15:8]; // [RULE13]
               tec_pkg::TEC_KIND_CTL:  rd_data_reg <= ctrl_reg[sel];
               tec_pkg::TEC_KIND_NONE: rd_data_reg <= 8'h00;
            endcase
         end
      end
   end

   // one-cycle request per overflow; masking is left to the cpu side
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_reg <= 3'h0;
      end else begin
         irq_reg <= ovf;                                               // [RULE7]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_sel_reg <= 2'h0;
      end else begin
         pin_sel_reg <= {ext_mode(ctrl_reg[1]), ext_mode(ctrl_reg[0])}; // [RULE16]
      end
   end

   assign rd_data           = rd_data_reg;
   assign rd_valid          = rd_valid_reg;
   assign irq               = irq_reg;
   assign pin_is_counter_in = pin_sel_reg;

endmodule

/* tec_top_properties.sv */
// port checker for the triple timer/event counter
`timescale 1ns/1ps
`include "tec_cfg.svh"

module tec_top_chk (
   input wire logic              clk,
   input wire logic              nrst,
   input wire tec_pkg::tec_req_t req,
   input wire logic [1:0]        ext_pin,
   input wire logic              lf_clk_pin,
   input wire logic [7:0]        rd_data,
   input wire logic              rd_valid,
   input wire logic [2:0]        irq,
   input wire logic [1:0]        pin_is_counter_in
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire ctl0_wr = req.wr && req.addr == `TEC_ADDR_C0_CTL;
   wire ctl_rd  = req.rd && req.addr inside {`TEC_ADDR_C0_CTL, `TEC_ADDR_C1_CTL, `TEC_ADDR_C2_CTL};

   a_read_answer: assert property (req.rd |=> rd_valid)
      else $error("read not answered");
   a_no_spur_valid: assert property (!req.rd |=> !rd_valid)
      else $error("read answer without request");
   a_data_holds: assert property (!req.rd |=> $stable(rd_data))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (req.rd && req.addr > 4'h8 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_ctl_spare_zero: assert property (ctl_rd |=> (rd_data & 8'h27) == 8'h00)
      else $error("spare control bits not zero");
   a_irq_single: assert property (|irq |=> (irq & $past(irq)) == 3'h0)
      else $error("overflow request longer than one cycle");
   a_irq0_spacing: assert property (irq[0] |=> !irq[0] [*3])
      else $error("counter0 overflows too close");
   a_irq2_spacing: assert property (irq[2] |=> !irq[2] [*3])
      else $error("counter2 overflows too close");
   a_pin_select: assert property (ctl0_wr && req.wdata[6] ##1 !ctl0_wr
      |-> ##[0:1] pin_is_counter_in[0])
      else $error("pin not taken as counter input");
   a_pin_release: assert property (ctl0_wr && !req.wdata[6] ##1 !ctl0_wr
      |-> ##[0:1] !pin_is_counter_in[0])
      else $error("pin still taken as counter input");
endmodule

bind tec_top tec_top_chk u_tec_top_chk (.clk(clk), .nrst(nrst), .req(req), .ext_pin(ext_pin),
   .lf_clk_pin(lf_clk_pin), .rd_data(rd_data), .rd_valid(rd_valid), .irq(irq),
   .pin_is_counter_in(pin_is_counter_in));

/* tec_src.sv */
// far-side source: event pulses on the pins and the 32768Hz clock
`timescale 1ns/1ps

module tec_src (
   input  wire logic  clk,
   output logic [1:0] pin,
   output logic       lf_clk
);
   initial begin
      pin = 2'h0;
      lf_clk = 1'b0;
      // oscillator runs free, unrelated in phase to clk
      forever #15259 lf_clk = ~lf_clk;
   end

   // high level held w clocks, low level w+1 between pulses; pins rest low between bursts
   task automatic pulse(input int ch, input int n, input int w);
      repeat (n) begin
         @(posedge clk);
         pin[ch] <= 1'b1;
         repeat (w) @(posedge clk);
         pin[ch] <= 1'b0;
         repeat (w) @(posedge clk);
      end
   endtask
endmodule

/* tb_top.sv */
// self-checking bench for the triple timer/event counter
`timescale 1ns/1ps
`include "tec_cfg.svh"

module tb_top;
   logic              clk;
   logic              nrst;
   tec_pkg::tec_req_t req;
   logic [1:0]        ext_pin;
   logic              lf_clk_pin;
   logic [7:0]        rd_data;
   logic              rd_valid;
   logic [2:0]        irq;
   logic [1:0]        pin_is_counter_in;
   int                miscompares;
   int                checks;
   logic [15:0]       v;
   logic [7:0]        b;

   tec_top u_tec_top (.clk(clk), .nrst(nrst), .req(req), .ext_pin(ext_pin),
      .lf_clk_pin(lf_clk_pin), .rd_data(rd_data), .rd_valid(rd_valid), .irq(irq),
      .pin_is_counter_in(pin_is_counter_in));
   tec_src u_tec_src (.clk(clk), .pin(ext_pin), .lf_clk(lf_clk_pin));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic ck(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic rng(input logic [15:0] got, input int lo, input int hi, input string m);
      checks++;
      if ($isunknown(got) || got < lo || got > hi) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h", $time, m, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      ck(16'(rd_valid), 16'h0001, "read valid");
      d = rd_data;
   endtask

   task automatic ld16(input int c, input logic [15:0] d);
      wr(4'(3 * c), d[7:0]);
      wr(4'(3 * c + 1), d[15:8]);
   endtask

   task automatic rd16(input int c, output logic [15:0] d);
      rd(4'(3 * c + 1), d[15:8]);
      rd(4'(3 * c), d[7:0]);
   endtask

   task automatic wait_irq(input int i, input int n);
      int k;
      k = 0;
      while (irq[i] !== 1'b1 && k < n) begin
         tick(1);
         k++;
      end
      ck(16'(k < n), 16'h0001, "overflow request");
      if (k >= n) finish_test;
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      miscompares++;
      finish_test;
   end

   initial begin
      req = '0;
      nrst = 1'b0;
      miscompares = 0;
      checks = 0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      for (int c = 0; c < 3; c++) begin
         rd16(c, v);
         ck(v, 16'h0000, "count at reset");
         rd(4'(3 * c + 2), b);
         ck(16'(b), 16'h0000, "control at reset");
      end
      rd(4'h9, b);
      ck(16'(b), 16'h0000, "unmapped read");
      done("reset");
      ld16(0, 16'h1234);
      wr(`TEC_ADDR_C0_LOW, 8'h56);
      rd16(0, v);
      ck(v, 16'h1234, "byte access");
      rd(`TEC_ADDR_C0_LOW, b);
      ck(16'(b), 16'h0034, "latched low");
      wr(`TEC_ADDR_C0_CTL, 8'hff);
      rd(`TEC_ADDR_C0_CTL, b);
      ck(16'(b), 16'h00d8, "control readback");
      wr(`TEC_ADDR_C0_CTL, 8'h00);
      done("bytes");
      // lf clock is slow, so counter1 gets only a couple of ticks here
      for (int c = 0; c < 3; c++) begin
         ld16(c, 16'h0000);
         wr(4'(3 * c + 2), 8'h90);
         repeat (1300) @(posedge clk);
         wr(4'(3 * c + 2), 8'h80);
         rd16(c, v);
         if (c == 1) rng(v, 1, 3, "slow clock count");
         else rng(v, 323, 328, "divided clock count");
      end
      done("timer");
      ld16(2, 16'hffc0);
      wr(`TEC_ADDR_C2_CTL, 8'h90);
      ld16(2, 16'h1234);
      rd16(2, v);
      ck(16'(v[15:8]), 16'h00ff, "running preload");
      wait_irq(2, 400);
      rd16(2, v);
      ck(16'(v[15:8]), 16'h0012, "reload");
      wr(`TEC_ADDR_C2_CTL, 8'h00);
      done("overflow");
      for (int c = 0; c < 2; c++) begin
         for (int e = 0; e < 2; e++) begin
            ld16(c, 16'hfffd);
            wr(4'(3 * c + 2), 8'h50 | 8'(e << 3));
            tick(2);
            ck(16'(pin_is_counter_in[c]), 16'h0001, "pin select");
            u_tec_src.pulse(c, 5, 4);
            tick(4);
            rd16(c, v);
            ck(v, 16'hffff, "event count");
            wr(4'(3 * c + 2), 8'h00);
         end
      end
      done("event");
      ld16(0, 16'h0000);
      wr(`TEC_ADDR_C0_CTL, 8'h10);
      u_tec_src.pulse(0, 3, 4);
      rd16(0, v);
      ck(v, 16'h0000, "idle mode");
      ck(16'(pin_is_counter_in[0]), 16'h0000, "pin free");
      wr(`TEC_ADDR_C0_CTL, 8'hd8);
      tick(8);
      u_tec_src.pulse(0, 1, 40);
      rd(`TEC_ADDR_C0_CTL, b);
      ck(16'(b), 16'h00c8, "run cleared");
      rd16(0, v);
      rng(v, 8, 12, "pulse width");
      ld16(0, 16'h0000);
      wr(`TEC_ADDR_C0_CTL, 8'hd0);
      tick(8);
      u_tec_src.pulse(0, 2, 40);
      rd(`TEC_ADDR_C0_CTL, b);
      ck(16'(b), 16'h00c0, "low pulse run cleared");
      rd16(0, v);
      rng(v, 8, 12, "low pulse width");
      done("pulse");
      ld16(2, 16'h0000);
      wr(`TEC_ADDR_C2_CTL, 8'h50);
      u_tec_src.pulse(0, 3, 4);
      rd16(2, v);
      ck(v, 16'h0000, "counter2 has no event mode");
      wr(`TEC_ADDR_C2_CTL, 8'h00);
      done("counter2 modes");
      finish_test;
   end
endmodule
